// file: sar_readout.sv
// Top module: frame sequencing, track/hold, serial word output, shutdown
`timescale 1ns/1ps
module sar_readout
    import sar_pkg::*;
(
    input wire logic clk, // System clock, 25 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic frame_sel_n, // Frame select from host, active low
    input wire logic sclk, // Shift clock from host
    input wire logic [DATA_BITS-1:0] conv_code, // Converter result code
    output logic serial_result_out, // Serial data output value
    output logic serial_result_oe, // Serial data output enable
    output logic hold, // Sampling stage in hold when high
    output logic sample_strobe, // Pulse when input is captured
    output logic aperture_mark, // Pulse at fourth falling edge
    output logic shutdown // Low-power shutdown mode
);
    // Last falling edge that still carries a data bit
    localparam logic [4:0] DATA_LAST_FALL = 5'(LEAD_ZEROS + DATA_BITS);

    // Link edges from the synchroniser
    sar_edge_if edges ();

    // Frame sequencing state and edge counts
    sar_state_t state;
    logic [4:0] fall_cnt;
    logic [4:0] rise_cnt;
    logic [4:0] next_fall;
    logic [4:0] next_rise;

    // Captured code and per-bit output selection
    logic [DATA_BITS-1:0] shift_word;
    logic [DATA_BITS-1:0] slot_bits;
    logic next_data_bit;

    // Decoded events within a frame
    logic fall_in_frame;
    logic rise_in_frame;
    logic last_fall;
    logic data_slot;
    logic track_rise;
    logic aperture_fall;
    logic shut_window;

    // Pin synchroniser and edge finder
    // Both pins pass two flops, so edges show two clocks after the pin moves;
    // each shift-clock half period must therefore span at least two clocks.
    sar_sync sar_sync_inst (
        .clk(clk), // System clock
        .reset(reset), // Synchronous reset
        .frame_sel_n(frame_sel_n), // Raw frame select pin
        .sclk(sclk), // Raw shift clock pin
        .edges(edges) // Synchronised edge events
    );

    // Edge counts as they stand once the current edge is taken
    assign next_fall = fall_cnt + 5'h01;
    assign next_rise = rise_cnt + 5'h01;

    // Shift-clock edges inside a live frame; all others are ignored
    assign fall_in_frame = state == SAR_FRAME && edges.sclk_fall;
    assign rise_in_frame = state == SAR_FRAME && edges.sclk_rise;

    // Word layout: the level shown at frame fall and falls one to three are zeros,
    // falls four to eleven carry the code MSB first, falls twelve to fifteen pad
    // with zeros and the sixteenth releases the line. A host that captures from
    // the first fall on therefore sees one extra leading zero.
    assign last_fall = fall_in_frame && next_fall == WORD_FALLS;
    assign data_slot = next_fall > LEAD_ZEROS && next_fall <= DATA_LAST_FALL;

    // Track return and aperture reference positions
    assign track_rise = rise_in_frame && next_rise == TRACK_RISE;
    assign aperture_fall = fall_in_frame && next_fall == APERTURE_FALL;

    // Early rise window; a rise before the second fall is taken as noise
    assign shut_window = fall_cnt >= SHUT_FIRST_FALL && fall_cnt < SHUT_LAST_FALL;

    // One select term per data bit, MSB in the first data slot
    for (genvar gi = 0; gi < DATA_BITS; gi++) begin : g_slot
        assign slot_bits[gi] = shift_word[gi] && next_fall == DATA_LAST_FALL - 5'(gi);
    end
    assign next_data_bit = |slot_bits;

    // Frame state
    // Done holds off further edges until the host raises frame select
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= SAR_IDLE;
        end else begin
            case (state)
                SAR_IDLE: begin
                    if (edges.frame_fall) begin
                        state <= SAR_FRAME;
                    end
                end
                SAR_FRAME: begin
                    if (edges.frame_rise) begin
                        state <= SAR_IDLE;
                    end else if (last_fall) begin
                        state <= SAR_DONE;
                    end
                end
                SAR_DONE: begin
                    // Edges after the sixteenth fall are refused
                    if (edges.frame_rise) begin
                        state <= SAR_IDLE;
                    end
                end
                default: begin
                    state <= SAR_IDLE;
                end
            endcase
        end
    end

    // Falling-edge count from frame fall
    // Five bits suffice: counting stops at the sixteenth fall
    always_ff @(posedge clk) begin
        if (reset) begin
            fall_cnt <= 5'h00;
        end else if (edges.frame_fall) begin
            fall_cnt <= 5'h00;
        end else if (fall_in_frame) begin
            fall_cnt <= next_fall;
        end
    end

    // Rising-edge count from frame fall, kept apart from falls
    always_ff @(posedge clk) begin
        if (reset) begin
            rise_cnt <= 5'h00;
        end else if (edges.frame_fall) begin
            rise_cnt <= 5'h00;
        end else if (rise_in_frame) begin
            rise_cnt <= next_rise;
        end
    end

    // Track/hold: hold from frame fall to thirteenth rise
    // A cut frame returns to track through the idle state
    always_ff @(posedge clk) begin
        if (reset) begin
            hold <= 1'b0;
        end else if (edges.frame_fall) begin
            hold <= 1'b1;
        end else if (track_rise) begin
            hold <= 1'b0;
        end else if (state == SAR_IDLE) begin
            hold <= 1'b0;
        end
    end

    // Input capture at frame fall, any 8-bit code in straight binary
    // Code must be steady when the synchronised frame fall is seen
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_word <= '0;
        end else if (edges.frame_fall) begin
            shift_word <= conv_code;
        end
    end

    // One-cycle pulse marking the capture
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= edges.frame_fall;
        end
    end

    // Aperture reference pulse at the fourth fall
    always_ff @(posedge clk) begin
        if (reset) begin
            aperture_mark <= 1'b0;
        end else begin
            aperture_mark <= aperture_fall;
        end
    end

    // Output enable: on at frame fall, off at sixteenth fall or frame rise
    // Whichever of the two comes first releases the line
    always_ff @(posedge clk) begin
        if (reset) begin
            serial_result_oe <= 1'b0;
        end else if (edges.frame_fall) begin
            serial_result_oe <= 1'b1;
        end else if (edges.frame_rise || last_fall) begin
            serial_result_oe <= 1'b0;
        end
    end

    // Output bit, changed on falling shift-clock edges and on frame edges
    // Frame edges force a zero so each word starts from a low level
    always_ff @(posedge clk) begin
        if (reset) begin
            serial_result_out <= 1'b0;
        end else if (edges.frame_fall || edges.frame_rise) begin
            serial_result_out <= 1'b0;
        end else if (fall_in_frame) begin
            if (data_slot) begin
                serial_result_out <= next_data_bit;
            end else begin
                serial_result_out <= 1'b0;
            end
        end
    end

    // Shutdown on a rise inside the early window, left at next frame fall
    // A rise after the tenth fall only cuts the word and keeps normal mode;
    // the power-up delay after shutdown is not modelled, so the first word
    // after wake-up carries a valid code here.
    always_ff @(posedge clk) begin
        if (reset) begin
            shutdown <= 1'b0;
        end else if (edges.frame_fall) begin
            shutdown <= 1'b0;
        end else if (state == SAR_FRAME && edges.frame_rise && shut_window) begin
            shutdown <= 1'b1;
        end
    end
endmodule

// file: sar_pkg.sv
// Package of constants and types for the serial converter readout block
package sar_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DATA_BITS = 8;
    localparam logic [4:0] LEAD_ZEROS = 5'h03;
    localparam logic [4:0] WORD_FALLS = 5'h10;
    localparam logic [4:0] TRACK_RISE = 5'h0d;
    localparam logic [4:0] APERTURE_FALL = 5'h04;
    localparam logic [4:0] SHUT_FIRST_FALL = 5'h02;
    localparam logic [4:0] SHUT_LAST_FALL = 5'h0a;
    localparam int QUIET_NS = 50;
    localparam int QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int THROUGHPUT_SCLK = 20;
    typedef enum logic [1:0] {SAR_IDLE, SAR_FRAME, SAR_DONE} sar_state_t;
endpackage

// file: sar_edge_if.sv
// Interface carrying synchronised link edges between modules
`timescale 1ns/1ps
interface sar_edge_if;
    logic frame_fall;
    logic frame_rise;
    logic frame_active;
    logic sclk_rise;
    logic sclk_fall;
    modport src (output frame_fall, frame_rise, frame_active, sclk_rise, sclk_fall);
    modport dst (input frame_fall, frame_rise, frame_active, sclk_rise, sclk_fall);
endinterface

// file: sar_sync.sv
// Two-stage synchroniser and edge finder for frame select and shift clock
`timescale 1ns/1ps
module sar_sync
    import sar_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic frame_sel_n, // Frame select pin, active low
    input wire logic sclk, // Shift clock pin
    sar_edge_if.src edges // Edge events out
);
    logic [1:0] cs_meta;
    logic [1:0] ck_meta;
    logic cs_prev;
    logic ck_prev;

    // Two flops per pin before any logic
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_meta <= 2'h3;
            ck_meta <= 2'h0;
        end else begin
            cs_meta <= {cs_meta[0], frame_sel_n};
            ck_meta <= {ck_meta[0], sclk};
        end
    end

    // Previous values for edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_prev <= 1'b1;
            ck_prev <= 1'b0;
        end else begin
            cs_prev <= cs_meta[1];
            ck_prev <= ck_meta[1];
        end
    end

    // Edge pulses
    assign edges.frame_fall = cs_prev & ~cs_meta[1];
    assign edges.frame_rise = ~cs_prev & cs_meta[1];
    assign edges.frame_active = ~cs_meta[1];
    assign edges.sclk_rise = ~ck_prev & ck_meta[1];
    assign edges.sclk_fall = ck_prev & ~ck_meta[1];
endmodule

// file: sar_readout_assertions.sv
// Checker on the readout top ports
`timescale 1ns/1ps
module sar_readout_assertions
    import sar_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic frame_sel_n, // Frame
    input wire logic serial_result_out, // Data
    input wire logic serial_result_oe, // Enable
    input wire logic hold, // Hold
    input wire logic sample_strobe, // Strobe
    input wire logic aperture_mark, // Mark
    input wire logic shutdown // Shutdown
);
    // Pin relations
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_hold; $fell(frame_sel_n) |-> ##[2:4] hold; endproperty
    a_hold: assert property (p_hold) else $error("hold late");
    property p_strb; $fell(frame_sel_n) |-> ##[2:5] sample_strobe; endproperty
    a_strb: assert property (p_strb) else $error("no strobe");
    property p_drv; $fell(frame_sel_n) |-> ##[2:4] serial_result_oe; endproperty
    a_drv: assert property (p_drv) else $error("no drive");
    property p_free; $rose(frame_sel_n) |-> ##[2:4] !serial_result_oe; endproperty
    a_free: assert property (p_free) else $error("no release");
    property p_idle; frame_sel_n [*6] |-> !serial_result_oe; endproperty
    a_idle: assert property (p_idle) else $error("idle drive");
    property p_lead; $rose(serial_result_oe) |-> !serial_result_out; endproperty
    a_lead: assert property (p_lead) else $error("lead bit");
    property p_mark; aperture_mark |-> hold ##1 !aperture_mark; endproperty
    a_mark: assert property (p_mark) else $error("mark");
    property p_shut; $rose(shutdown) |-> frame_sel_n; endproperty
    a_shut: assert property (p_shut) else $error("shutdown");
    property p_wake; $fell(frame_sel_n) |-> ##[2:5] !shutdown; endproperty
    a_wake: assert property (p_wake) else $error("wake");
endmodule
bind sar_readout sar_readout_assertions chk (.clk(clk), .reset(reset), .frame_sel_n(frame_sel_n),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe), .hold(hold),
    .sample_strobe(sample_strobe), .aperture_mark(aperture_mark), .shutdown(shutdown));

// file: sar_host.sv
// Host model driving frame select and shift clock
`timescale 1ns/1ps
module sar_host (
    input wire logic clk, // Pacing clock
    input wire logic sdo, // Data value
    input wire logic sdo_oe, // Data enable
    input wire logic hold, // Track/hold state
    output logic frame_sel_n = 1'b1, // Frame, active low
    output logic sclk = 1'b0 // Shift clock, still between frames
);
    logic last = 1'b0;
    logic [15:0] word;
    logic [15:0] trace;
    logic [7:0] sample = 8'h00;
    int n_samples = 0;
    wire sd = sdo_oe ? sdo : ~last;
    // Released line shows inverse of last bit
    always @(posedge clk) if (sdo_oe) last <= sdo;
    // One frame of n cycles, then the gap
    task automatic run(input int n);
        frame_sel_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            word = {word[14:0], sd};
            trace = {trace[14:0], hold};
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        frame_sel_n = 1'b1;
        // Only a full frame yields a sample; a cut word is dropped
        if (n == 16) begin
            sample = word[11:4];
            n_samples++;
        end
        repeat (36) @(negedge clk);
    endtask
endmodule

// file: sar_readout_tb.sv
// Self-checking bench for the readout block
`timescale 1ns/1ps
module sar_readout_tb;
    import sar_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [DATA_BITS-1:0] conv_code = 8'h00;
    wire frame_sel_n, sclk, sdo, oe, hold, shut, strb, mark;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_strobe = 0;
    int n_mark = 0;
    // Count capture and aperture pulses between clock edges
    always @(negedge clk) begin
        if (strb === 1'b1) n_strobe++;
        if (mark === 1'b1) n_mark++;
    end
    // Clock at 25 MHz
    always #20 clk = ~clk;
    sar_readout sar_readout_inst (.clk(clk), .reset(reset), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .conv_code(conv_code), .serial_result_out(sdo), .serial_result_oe(oe), .hold(hold),
        .sample_strobe(strb), .aperture_mark(mark), .shutdown(shut));
    sar_host host (.clk(clk), .sdo(sdo), .sdo_oe(oe), .hold(hold), .frame_sel_n(frame_sel_n), .sclk(sclk));
    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Full frame: word, track return, release
    task automatic t_word(input logic [7:0] code);
        int p0;
        int s0;
        int m0;
        p0 = host.n_samples;
        s0 = n_strobe;
        m0 = n_mark;
        conv_code = code;
        host.run(16);
        check(host.word, {4'h0, code, 4'h0});
        check(host.trace, 16'hfff0);
        check({14'h0, oe, shut}, 16'h0000);
        check({8'h00, host.sample}, {8'h00, code});
        check(16'(host.n_samples - p0), 16'h0001);
        check(16'(n_strobe - s0), 16'h0001);
        check(16'(n_mark - m0), 16'h0001);
    endtask
    // Cut frame: release and shutdown choice
    task automatic t_cut(input int n, input logic s);
        int p0;
        int m0;
        p0 = host.n_samples;
        m0 = n_mark;
        host.run(n);
        check({14'h0, oe, shut}, {15'h0, s});
        check(16'(host.n_samples - p0), 16'h0000);
        check(16'(n_mark - m0), {15'h0, n >= int'(APERTURE_FALL)});
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("Error at %0t: timeout", $time);
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        t_word(8'h00);
        t_word(8'hff);
        t_word(8'ha5);
        t_word(8'h5a);
        t_cut(1, 1'b0);
        t_cut(12, 1'b0);
        t_cut(10, 1'b0);
        t_cut(2, 1'b1);
        t_word(8'h3c);
        t_cut(9, 1'b1);
        t_word(8'hc3);
        print_verdict();
    end
endmodule
